/* src/adcac_pkg.sv */
// Contract
// - Resolution select at 0 gives 10-bit results and at 1 gives 8-bit results.
// - In normal track mode an enabled converter starts converting right on the start event.
// - In delayed track mode the input keeps tracking for 3 conversion clocks before converting.
// - Gain select gives an input gain of one half when clear and unity when set.
// - Outside burst with accumulation off, each result overwrites the result byte pair.
// - Outside burst with accumulation on, each result is added to the held result pair.
// - The accumulate enable is write-only and its bit always reads as zero.
// - Justify codes 000 to 011 read the accumulator right justified, shifted by 0 to 3.
// - Justify code 100 reads the result left justified, and higher codes are reserved.
// - In burst mode the repeat field runs and sums 1, 4, 8, 16, 32 or 64 conversions.
// - The accumulator is 16 bits, read as formatted halves and loaded a half per write.
// - The done flag sets after a single conversion or a whole burst and stays until cleared.
// - Burst mode enable selects burst operation when set and single conversions when clear.
package adcac_pkg;

   // ==========================================================
   // Register addresses
   localparam logic [7:0] ADDR_ACC_CFG  = 8'hBA;
   localparam logic [7:0] ADDR_CONV_CFG = 8'hBC;
   localparam logic [7:0] ADDR_RES_LOW  = 8'hBD;
   localparam logic [7:0] ADDR_RES_HIGH = 8'hBE;
   localparam logic [7:0] ADDR_CTRL     = 8'hC0;

   // ==========================================================
   // Reset values
   localparam logic [7:0]  CONV_CFG_RST = 8'hF8;
   localparam logic [6:0]  ACC_CFG_RST  = 7'h00;
   localparam logic [15:0] ACC_RST      = 16'h0000;

   // ==========================================================
   // Field positions
   localparam int CFG_EIGHT_BIT     = 2;
   localparam int CFG_DELAYED_TRACK = 1;
   localparam int CFG_GAIN          = 0;
   localparam int AC_ACCUM_EN       = 6;
   localparam int AC_SJST_LSB       = 3;
   localparam int AC_RPT_LSB        = 0;
   localparam int CTRL_ENABLE       = 7;
   localparam int CTRL_BURST        = 6;
   localparam int CTRL_DONE         = 5;
   localparam int CTRL_BUSY         = 4;

   // ==========================================================
   // Codes and counts
   localparam logic [2:0] SJST_LEFT           = 3'h4;
   localparam logic [1:0] DELAYED_TRACK_TICKS = 2'h3;
   localparam int         SAR_WIDTH           = 10;
   localparam int         ACC_WIDTH           = 16;
   localparam int         EIGHT_BIT_LEFT_SHL  = 8;
   localparam int         TEN_BIT_LEFT_SHL    = 6;

   typedef enum logic [1:0] {
      ADCAC_IDLE,
      ADCAC_TRACK,
      ADCAC_CONV
   } adcac_fsm_t;

   // Reserved repeat codes fall back to a single conversion.
   function automatic logic [6:0] adcac_rpt_count(input logic [2:0] code);
      case (code)
         3'h1:    adcac_rpt_count = 7'h04;
         3'h2:    adcac_rpt_count = 7'h08;
         3'h3:    adcac_rpt_count = 7'h10;
         3'h4:    adcac_rpt_count = 7'h20;
         3'h5:    adcac_rpt_count = 7'h40;
         default: adcac_rpt_count = 7'h01;
      endcase
   endfunction

endpackage

/* src/adcac_result_fmt.sv */
`timescale 1ns/1ps
`default_nettype none
module adcac_result_fmt (
   input  wire logic [15:0] acc_i,       // Raw accumulator
   input  wire logic [2:0]  sjst_i,      // Shift and justify code
   input  wire logic        eight_bit_i, // Converter in 8-bit mode
   output logic      [15:0] fmt_o        // Formatted read value
);
   import adcac_pkg::*;

   // ==========================================================
   // Formatting
   always_comb begin
      case (sjst_i)
         3'h1:    fmt_o = acc_i >> 1;
         3'h2:    fmt_o = acc_i >> 2;
         3'h3:    fmt_o = acc_i >> 3;
         SJST_LEFT: begin
            if (eight_bit_i) begin
               fmt_o = acc_i << EIGHT_BIT_LEFT_SHL;
            end else begin
               fmt_o = acc_i << TEN_BIT_LEFT_SHL;
            end
         end
         default: fmt_o = acc_i;
      endcase
   end
endmodule
`default_nettype wire

/* src/adcac_top.sv */
`timescale 1ns/1ps
`default_nettype none
module adcac_top (
   input  wire logic                            clk_sys_i,     // System clock
   input  wire logic                            rst_n_i,       // Sync reset, active low
   input  wire logic [7:0]                      sfr_addr_i,    // Register address
   input  wire logic [7:0]                      sfr_wdata_i,   // Write data
   input  wire logic                            sfr_wr_i,      // Write strobe
   input  wire logic                            sfr_rd_i,      // Read strobe
   output logic      [7:0]                      sfr_rdata_o,   // Read data, next cycle
   input  wire logic                            soc_i,         // Start-of-conversion pulse
   input  wire logic                            sar_tick_i,    // Conversion clock tick
   input  wire logic                            sar_done_i,    // Conversion finished pulse
   input  wire logic [adcac_pkg::SAR_WIDTH-1:0] sar_data_i,    // Conversion result
   output logic                                 sar_start_o,   // Begin converting pulse
   output logic                                 sar_track_o,   // Input tracking level
   output logic                                 eight_bit_o,   // eight_bit_select
   output logic                                 gain_unity_o,  // input_gain_select
   output logic                                 done_flag_o    // conversion_done_flag
);
   import adcac_pkg::*;

   typedef struct packed {
      adcac_fsm_t  fsm;
      logic [7:0]  conv_cfg;
      logic [6:0]  acc_cfg;
      logic        enable;
      logic        burst;
      logic        done;
      logic [15:0] acc;
      logic [1:0]  trk_cnt;
      logic [6:0]  conv_cnt;
      logic        start;
      logic        track;
      logic [7:0]  rdata;
   } adcac_state_t;

   adcac_state_t st;
   adcac_state_t next_st;
   logic [15:0]  fmt;
   logic [15:0]  sample;
   logic         soc;
   logic         delayed;

   // ==========================================================
   // Read formatting
   adcac_result_fmt u_fmt (
      .acc_i       (st.acc),
      .sjst_i      (st.acc_cfg[AC_SJST_LSB+:3]),
      .eight_bit_i (st.conv_cfg[CFG_EIGHT_BIT]),
      .fmt_o       (fmt)
   );

   // ==========================================================
   // Next state
   always_comb begin
      next_st       = st;
      next_st.start = 1'b0;
      soc           = soc_i | (sfr_wr_i & (sfr_addr_i == ADDR_CTRL) & sfr_wdata_i[CTRL_BUSY]);
      delayed       = st.conv_cfg[CFG_DELAYED_TRACK];
      // 8-bit mode drops the upper result bits
      if (st.conv_cfg[CFG_EIGHT_BIT]) begin
         sample = {8'h00, sar_data_i[7:0]};
      end else begin
         sample = {6'h00, sar_data_i};
      end

      // Register writes; the done flag set below still wins over a clear.
      if (sfr_wr_i) begin
         case (sfr_addr_i)
            ADDR_CONV_CFG: next_st.conv_cfg = sfr_wdata_i;
            ADDR_ACC_CFG:  next_st.acc_cfg  = sfr_wdata_i[6:0];
            ADDR_CTRL: begin
               next_st.enable = sfr_wdata_i[CTRL_ENABLE];
               next_st.burst  = sfr_wdata_i[CTRL_BURST];
               next_st.done   = sfr_wdata_i[CTRL_DONE];
            end
            default: ;
         endcase
      end

      case (st.fsm)
         ADCAC_IDLE: begin
            if (soc && (st.enable || st.burst)) begin
               next_st.conv_cnt = 7'h00;
               if (st.burst) begin
                  next_st.acc = ACC_RST;
               end
               if (delayed) begin
                  next_st.fsm     = ADCAC_TRACK;
                  next_st.trk_cnt = 2'h0;
               end else begin
                  next_st.fsm   = ADCAC_CONV;
                  next_st.start = 1'b1;
               end
            end
         end
         ADCAC_TRACK: begin
            if (sar_tick_i) begin
               if (st.trk_cnt == DELAYED_TRACK_TICKS - 2'h1) begin
                  next_st.fsm   = ADCAC_CONV;
                  next_st.start = 1'b1;
               end else begin
                  next_st.trk_cnt = st.trk_cnt + 2'h1;
               end
            end
         end
         ADCAC_CONV: begin
            if (sar_done_i) begin
               if (st.burst || st.acc_cfg[AC_ACCUM_EN]) begin
                  next_st.acc = st.acc + sample;
               end else begin
                  next_st.acc = sample;
               end
               next_st.conv_cnt = st.conv_cnt + 7'h01;
               if (!st.burst ||
                   (st.conv_cnt + 7'h01 == adcac_rpt_count(st.acc_cfg[AC_RPT_LSB+:3]))) begin
                  next_st.fsm  = ADCAC_IDLE;
                  next_st.done = 1'b1;
               end else if (delayed) begin
                  next_st.fsm     = ADCAC_TRACK;
                  next_st.trk_cnt = 2'h0;
               end else begin
                  next_st.start = 1'b1;
               end
            end
         end
         default: next_st.fsm = ADCAC_IDLE;
      endcase

      // direct half loads; a write beats a same-cycle result
      if (sfr_wr_i && (sfr_addr_i == ADDR_RES_HIGH)) begin
         next_st.acc[15:8] = sfr_wdata_i;
      end
      if (sfr_wr_i && (sfr_addr_i == ADDR_RES_LOW)) begin
         next_st.acc[7:0] = sfr_wdata_i;
      end

      next_st.track = (next_st.fsm != ADCAC_CONV);

      if (sfr_rd_i) begin
         case (sfr_addr_i)
            ADDR_CONV_CFG: next_st.rdata = st.conv_cfg;
            ADDR_ACC_CFG:  next_st.rdata = {2'b00, st.acc_cfg[5:0]};
            ADDR_RES_HIGH: next_st.rdata = fmt[15:8];
            ADDR_RES_LOW:  next_st.rdata = fmt[7:0];
            ADDR_CTRL:     next_st.rdata = {st.enable, st.burst, st.done,
                                            (st.fsm != ADCAC_IDLE), 4'h0};
            default:       next_st.rdata = 8'h00;
         endcase
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         st.fsm      <= ADCAC_IDLE;
         st.conv_cfg <= CONV_CFG_RST;
         st.acc_cfg  <= ACC_CFG_RST;
         st.enable   <= 1'b0;
         st.burst    <= 1'b0;
         st.done     <= 1'b0;
         st.acc      <= ACC_RST;
         st.trk_cnt  <= 2'h0;
         st.conv_cnt <= 7'h00;
         st.start    <= 1'b0;
         st.track    <= 1'b1;
         st.rdata    <= 8'h00;
      end else begin
         st <= next_st;
      end
   end

   assign sfr_rdata_o  = st.rdata;
   assign sar_start_o  = st.start;
   assign sar_track_o  = st.track;
   assign eight_bit_o  = st.conv_cfg[CFG_EIGHT_BIT];
   assign gain_unity_o = st.conv_cfg[CFG_GAIN];
   assign done_flag_o  = st.done;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   property p_eight_bit;
      sfr_wr_i && sfr_addr_i == ADDR_CONV_CFG |=> eight_bit_o == $past(sfr_wdata_i[CFG_EIGHT_BIT]);
   endproperty
   a_eight_bit: assert property (p_eight_bit) else $error("resolution select not applied");

   property p_immediate;
      st.fsm == ADCAC_IDLE && soc && st.enable && !delayed |=> sar_start_o && !sar_track_o;
   endproperty
   a_immediate: assert property (p_immediate) else $error("normal track start late");

   property p_delayed;
      st.fsm == ADCAC_IDLE && soc && st.enable && delayed |=> sar_track_o && !sar_start_o;
   endproperty
   a_delayed: assert property (p_delayed) else $error("delayed track skipped");

   property p_track_len;
      st.fsm == ADCAC_TRACK && next_st.fsm == ADCAC_CONV |-> st.trk_cnt == 2'h2 && sar_tick_i;
   endproperty
   a_track_len: assert property (p_track_len) else $error("track interval not 3 ticks");

   property p_gain;
      sfr_wr_i && sfr_addr_i == ADDR_CONV_CFG |=> gain_unity_o == $past(sfr_wdata_i[CFG_GAIN]);
   endproperty
   a_gain: assert property (p_gain) else $error("gain select not applied");

   property p_overwrite;
      st.fsm == ADCAC_CONV && sar_done_i && !st.burst && !st.acc_cfg[AC_ACCUM_EN] && !sfr_wr_i
      |=> st.acc == $past(sample);
   endproperty
   a_overwrite: assert property (p_overwrite) else $error("result not overwritten");

   property p_accumulate;
      st.fsm == ADCAC_CONV && sar_done_i && st.acc_cfg[AC_ACCUM_EN] && !sfr_wr_i
      |=> st.acc == $past(st.acc) + $past(sample);
   endproperty
   a_accumulate: assert property (p_accumulate) else $error("result not accumulated");

   property p_ae_reads_zero;
      sfr_rd_i && sfr_addr_i == ADDR_ACC_CFG |=> !sfr_rdata_o[AC_ACCUM_EN] && !sfr_rdata_o[7];
   endproperty
   a_ae_reads_zero: assert property (p_ae_reads_zero) else $error("write-only bit visible");

   property p_right_just;
      sfr_rd_i && sfr_addr_i == ADDR_RES_HIGH && st.acc_cfg[5:3] == 3'h0
      |=> sfr_rdata_o == $past(st.acc[15:8]);
   endproperty
   a_right_just: assert property (p_right_just) else $error("unshifted high byte wrong");

   property p_burst_len;
      st.fsm == ADCAC_CONV && sar_done_i && st.burst && next_st.fsm == ADCAC_IDLE
      |-> st.conv_cnt + 7'h01 == adcac_rpt_count(st.acc_cfg[2:0]);
   endproperty
   a_burst_len: assert property (p_burst_len) else $error("burst length wrong");

   property p_done_set;
      st.fsm == ADCAC_CONV && sar_done_i && !st.burst
      |=> done_flag_o ##1 (done_flag_o || $past(sfr_wr_i && sfr_addr_i == ADDR_CTRL));
   endproperty
   a_done_set: assert property (p_done_set) else $error("done flag not sticky");

   property p_reserved_sjst;
      sfr_rd_i && sfr_addr_i == ADDR_RES_LOW && st.acc_cfg[5:3] > SJST_LEFT
      |=> sfr_rdata_o == $past(st.acc[7:0]);
   endproperty
   a_reserved_sjst: assert property (p_reserved_sjst) else $error("reserved code not as 000");

   property p_idle_quiet;
      st.fsm == ADCAC_IDLE && !soc |=> !sar_start_o && sar_track_o;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("start without request");

   property p_done_clear;
      sfr_wr_i && sfr_addr_i == ADDR_CTRL && !sfr_wdata_i[CTRL_DONE] && !sar_done_i
      |=> !done_flag_o;
   endproperty
   a_done_clear: assert property (p_done_clear) else $error("done flag kept");

   property p_load_high;
      sfr_wr_i && sfr_addr_i == ADDR_RES_HIGH |=> st.acc[15:8] == $past(sfr_wdata_i);
   endproperty
   a_load_high: assert property (p_load_high) else $error("high byte not loaded");

   property p_load_low;
      sfr_wr_i && sfr_addr_i == ADDR_RES_LOW |=> st.acc[7:0] == $past(sfr_wdata_i);
   endproperty
   a_load_low: assert property (p_load_low) else $error("low byte not loaded");

   property p_left_just;
      sfr_rd_i && sfr_addr_i == ADDR_RES_HIGH && st.acc_cfg[5:3] == SJST_LEFT &&
      !st.conv_cfg[CFG_EIGHT_BIT] |=> sfr_rdata_o == $past(st.acc[9:2]);
   endproperty
   a_left_just: assert property (p_left_just) else $error("left justify wrong");

   property p_shift_one;
      sfr_rd_i && sfr_addr_i == ADDR_RES_LOW && st.acc_cfg[5:3] == 3'h1
      |=> sfr_rdata_o == $past(st.acc[8:1]);
   endproperty
   a_shift_one: assert property (p_shift_one) else $error("one-bit shift wrong");

   property p_byte_sample;
      st.conv_cfg[CFG_EIGHT_BIT] && st.fsm == ADCAC_CONV && sar_done_i && !sfr_wr_i &&
      (st.burst || st.acc_cfg[AC_ACCUM_EN])
      |=> st.acc == $past(st.acc) + $past({8'h00, sar_data_i[7:0]});
   endproperty
   a_byte_sample: assert property (p_byte_sample) else $error("8-bit sum wrong");

   property p_burst_clear;
      st.fsm == ADCAC_IDLE && soc && st.burst && !sfr_wr_i |=> st.acc == ACC_RST;
   endproperty
   a_burst_clear: assert property (p_burst_clear) else $error("burst sum kept");

endmodule
`default_nettype wire

/* sim/adc_accumulator_config_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_accumulator_config_tb;
   import adcac_pkg::*;
   // ==========================================================
   // Stimulus and state
   logic        clk_sys_i   = 1'b0;
   logic        rst_n_i     = 1'b0;
   logic [7:0]  sfr_addr_i  = 8'h00;
   logic [7:0]  sfr_wdata_i = 8'h00;
   logic        sfr_wr_i    = 1'b0;
   logic        sfr_rd_i    = 1'b0;
   logic        soc_i       = 1'b0;
   logic        sar_tick_i  = 1'b0;
   logic        sar_done_i  = 1'b0;
   logic [9:0]  sar_data_i  = 10'h000;
   logic [7:0]  sfr_rdata_o;
   logic        sar_start_o;
   logic        sar_track_o;
   logic        eight_bit_o;
   logic        gain_unity_o;
   logic        done_flag_o;
   logic        rd_seen     = 1'b0;
   logic [7:0]  exp_q[$];
   logic [31:0] seed        = 32'h5C75;
   logic [15:0] sum         = 16'h0000;
   logic        mode8       = 1'b0;
   int          n_mismatch  = 0;
   int          checks      = 0;
   int          n_conv      = 0;

   always #5 clk_sys_i = ~clk_sys_i;

   adcac_top u_adcac_top (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i),
      .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
      .sfr_rdata_o(sfr_rdata_o), .soc_i(soc_i), .sar_tick_i(sar_tick_i),
      .sar_done_i(sar_done_i), .sar_data_i(sar_data_i), .sar_start_o(sar_start_o),
      .sar_track_o(sar_track_o), .eight_bit_o(eight_bit_o),
      .gain_unity_o(gain_unity_o), .done_flag_o(done_flag_o)
   );

   // ==========================================================
   // Helpers
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction

   // Reserved justify codes read as code 000.
   function automatic logic [15:0] fmt(input logic [15:0] a, input logic [2:0] sj);
      case (sj)
         3'h1, 3'h2, 3'h3: return a >> sj;
         3'h4:             return a << 6;
         default:          return a;
      endcase
   endfunction

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t value 0x%h expected 0x%h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp, input string what);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t %s is %b", $time, what, got);
      end
   endtask

   task automatic summarize();
      if (n_mismatch == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      sfr_addr_i  <= a;
      sfr_wdata_i <= d;
      sfr_wr_i    <= 1'b1;
      @(posedge clk_sys_i) sfr_wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys_i);
      sfr_addr_i <= a;
      sfr_rd_i   <= 1'b1;
      exp_q.push_back(exp);
      @(posedge clk_sys_i) sfr_rd_i <= 1'b0;
   endtask

   task automatic rd_res(input logic [2:0] sj);
      logic [15:0] f;
      f = fmt(sum, sj);
      rd(ADDR_RES_HIGH, f[15:8]);
      rd(ADDR_RES_LOW, f[7:0]);
   endtask

   task automatic go();
      @(posedge clk_sys_i) soc_i <= 1'b1;
      @(posedge clk_sys_i) soc_i <= 1'b0;
   endtask

   task automatic finish_conv(input int n0);
      int k;
      k = 0;
      while (n_conv == n0 && k < 50) begin
         @(posedge clk_sys_i);
         k++;
      end
      repeat (2) @(posedge clk_sys_i);
      #1 chk1(done_flag_o, 1'b1, "done set");
      chk1(sar_track_o, 1'b1, "tracking");
      wr(ADDR_CTRL, 8'h80);
      #1 chk1(done_flag_o, 1'b0, "done clear");
   endtask

   // ==========================================================
   // Checking and converter stand-in
   always @(posedge clk_sys_i) rd_seen <= sfr_rd_i;

   always @(negedge clk_sys_i) begin
      if (rd_seen && exp_q.size() > 0) begin
         chk8(sfr_rdata_o, exp_q.pop_front());
      end
   end

   // The data line shows the inverse of the last result once done drops,
   // so a design that samples it late cannot pass by luck.
   initial begin : responder
      int         dly;
      logic [9:0] d;
      forever begin
         @(posedge clk_sys_i);
         if (sar_start_o === 1'b1) begin
            seed = xs(seed);
            dly  = 1 + int'(seed[1:0]);
            d    = seed[17:8];
            repeat (dly) @(posedge clk_sys_i);
            sar_data_i <= d;
            sar_done_i <= 1'b1;
            @(posedge clk_sys_i);
            sar_done_i <= 1'b0;
            sar_data_i <= ~d;
            sum = sum + (mode8 ? {8'h00, d[7:0]} : {6'h00, d});
            n_conv++;
         end
      end
   end

   initial begin : watchdog
      #400000;
      n_mismatch++;
      $display("BAD %0t timeout", $time);
      summarize();
   end

   // ==========================================================
   // Sequence
   initial begin : main
      int n0;
      int k;
      repeat (12) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      rd(ADDR_ACC_CFG, 8'h00);
      rd(ADDR_CONV_CFG, CONV_CFG_RST);
      rd(ADDR_RES_HIGH, 8'h00);
      rd(8'h55, 8'h00);
      wr(ADDR_CONV_CFG, 8'h07);
      #1 chk1(eight_bit_o, 1'b1, "eight bit");
      chk1(gain_unity_o, 1'b1, "gain");
      rd(ADDR_CONV_CFG, 8'h07);
      wr(ADDR_CONV_CFG, 8'hF8);
      #1 chk1(eight_bit_o, 1'b0, "eight bit");
      chk1(gain_unity_o, 1'b0, "gain");
      wr(ADDR_CTRL, 8'h80);
      for (int i = 0; i < 5; i++) begin
         if (i == 2) begin
            wr(ADDR_ACC_CFG, 8'h40);
            wr(ADDR_RES_LOW, 8'h00);
            wr(ADDR_RES_HIGH, 8'h00);
         end
         // The expected sum restarts with every overwrite and after the clear above.
         if (i < 3) sum = 16'h0000;
         n0 = n_conv;
         // The last pass starts through the control register instead of the pin.
         if (i == 4) wr(ADDR_CTRL, 8'h90);
         else go();
         #1 chk1(sar_start_o, 1'b1, "start");
         finish_conv(n0);
         rd_res(3'h0);
      end
      wr(ADDR_RES_HIGH, 8'h12);
      wr(ADDR_RES_LOW, 8'h34);
      sum = 16'h1234;
      for (int sj = 0; sj < 8; sj++) begin
         wr(ADDR_ACC_CFG, 8'h40 | 8'(sj << 3));
         rd(ADDR_ACC_CFG, 8'(sj << 3));
         rd_res(3'(sj));
      end
      wr(ADDR_ACC_CFG, 8'h00);
      wr(ADDR_CONV_CFG, 8'hFA);
      sum = 16'h0000;
      n0  = n_conv;
      go();
      for (int t = 0; t < 3; t++) begin
         repeat (3) @(posedge clk_sys_i);
         #1 chk1(sar_start_o | ~sar_track_o, 1'b0, "early start");
         @(posedge clk_sys_i) sar_tick_i <= 1'b1;
         @(posedge clk_sys_i) sar_tick_i <= 1'b0;
      end
      #1;
      k = 0;
      while (sar_start_o !== 1'b1 && k < 2) begin
         @(posedge clk_sys_i);
         #1 k++;
      end
      chk1(sar_start_o, 1'b1, "delayed start");
      finish_conv(n0);
      rd_res(3'h0);
      // Bursts run in 8-bit mode, so only the low data bits may enter the sum.
      wr(ADDR_CONV_CFG, 8'hFC);
      mode8 = 1'b1;
      #1 chk1(eight_bit_o, 1'b1, "eight bit");
      wr(ADDR_CTRL, 8'hC0);
      for (int c = 0; c < 7; c++) begin
         wr(ADDR_ACC_CFG, 8'(c));
         sum = 16'h0000;
         n0  = n_conv;
         go();
         k = 0;
         while (done_flag_o !== 1'b1 && k < 3000) begin
            @(posedge clk_sys_i);
            k++;
         end
         repeat (2) @(posedge clk_sys_i);
         chk8(8'(n_conv - n0), (c == 0 || c == 6) ? 8'h01 : 8'(1 << (c + 1)));
         rd_res(3'h0);
         rd(ADDR_CTRL, 8'hE0);
         #1 chk1(done_flag_o, 1'b1, "burst done");
         wr(ADDR_CTRL, 8'hC0);
      end
      wr(ADDR_ACC_CFG, 8'h00);
      summarize();
   end
endmodule
`default_nettype wire
